// >>> rtl/period_match_timer8_defs.svh
`ifndef PERIOD_MATCH_TIMER8_DEFS_SVH
`define PERIOD_MATCH_TIMER8_DEFS_SVH

// register byte offsets on the bus
`define PMT_OFF_CTRL 8'h00
`define PMT_OFF_COUNT 8'h04
`define PMT_OFF_PERIOD 8'h08
`define PMT_OFF_STATUS 8'h0C
`define PMT_OFF_MASK 8'h10

// control register field positions
`define PMT_CTRL_PRE_LO 0
`define PMT_CTRL_PRE_HI 1
`define PMT_CTRL_RUN 2
`define PMT_CTRL_POST_LO 3
`define PMT_CTRL_POST_HI 6

// status and mask bit position
`define PMT_EVT_MATCH 0

// reset values
`define PMT_RST_COUNT 8'h00
`define PMT_RST_PERIOD 8'hFF
`define PMT_RST_PRE_SEL 2'h0
`define PMT_RST_POST_SEL 4'h0
`define PMT_RST_SCALE_CNT 4'h0
`define PMT_RST_WORD 32'h0000_0000

// prescale terminal counts for divide by 1, 4 and 16
`define PMT_PRE_LAST_DIV1 4'h0
`define PMT_PRE_LAST_DIV4 4'h3
`define PMT_PRE_LAST_DIV16 4'hF

// instruction clock is the core clock divided by four
`define PMT_INSTR_DIV 4

`endif

// >>> rtl/period_match_timer8_pkg.sv
package period_match_timer8_pkg;

  // bus slave phase, one-hot
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_ACCESS = 2'b10
  } apb_phase_t;

  // complete state of the timer block
  typedef struct packed {
    apb_phase_t phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] pre_sel;
    logic run;
    logic [3:0] post_sel;
    logic [7:0] count;
    logic [7:0] period;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic flag;
    logic mask;
    logic match_out;
    logic post_event;
    logic irq;
  } timer_state_t;

endpackage : period_match_timer8_pkg

// >>> rtl/instr_clock_divider.sv
`timescale 1ns/100ps
`include "period_match_timer8_defs.svh"

// one-cycle enable pulse every DIV core clocks
module instr_clock_divider #(
  parameter int DIV = `PMT_INSTR_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  // a divide below two would leave no slower rate at all
  if (DIV < 2) begin : g_bad_div
    $error("instr_clock_divider: DIV must be at least 2");
  end

  // free running, so the tick phase never depends on software
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = (st_r.cnt == LAST);
    if (st_r.cnt == LAST) begin
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule : instr_clock_divider

// >>> rtl/period_match_timer8.sv
// Summary of operation
// - An 8-bit count advances by one from zero on each prescaled instruction tick.
// - A 4-bit prescale counter sits between the instruction tick and the count.
// - Prescale select 00 divides by one, 01 by four, and 1x by sixteen.
// - The count is compared with the period every cycle and equality gives a match.
// - A match returns the count to zero on the next tick and feeds the postscaler.
// - Postscale select n gives one event for every n plus one matches, 1:1 to 1:16.
// - Software reads and writes the count and the period directly.
// - Reset clears the count and sets the period to all ones.
// - Writes to count or control, and reset, clear both scale counters.
// - A control write leaves the count untouched.
// - The run bit starts the timer when one and stops it when zero.
// - Control bit 7 has no storage and reads zero.
// - A postscaler event latches the match flag; interrupt only when enabled.
// - The unscaled match is driven out as a time base for other units.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "period_match_timer8_defs.svh"

module period_match_timer8 #(
  parameter int ADDR_W = 8,
  parameter int INSTR_DIV = `PMT_INSTR_DIV
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic time_base,
  output logic post_event,
  output logic irq
);

  // the decoder looks at byte offsets up to 8'h10
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
    $error("period_match_timer8: ADDR_W must lie between 5 and 8");
  end

  // reset release through two flops
  logic rst_meta_r;
  logic rst_n_r;

  period_match_timer8_pkg::timer_state_t st_r;
  period_match_timer8_pkg::timer_state_t st_nxt;

  logic instr_tick;

  // widened address, so the decoder always sees eight bits
  logic [7:0] addr8;

  // combinational helpers of the next-state process
  logic xfer;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_count;
  logic wr_period;
  logic wr_status;
  logic wr_mask;
  logic pre_tick;
  logic hit;
  logic match;
  logic post_done;

  // terminal prescale count for a select value
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    logic [3:0] last;
    last = `PMT_PRE_LAST_DIV16;
    case (sel)
      2'h0: last = `PMT_PRE_LAST_DIV1;
      2'h1: last = `PMT_PRE_LAST_DIV4;
      default: last = `PMT_PRE_LAST_DIV16;
    endcase
    return last;
  endfunction : pre_last

  // true for an aligned, mapped register offset
  function automatic logic addr_hit(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    case (a)
      `PMT_OFF_CTRL: ok = 1'b1;
      `PMT_OFF_COUNT: ok = 1'b1;
      `PMT_OFF_PERIOD: ok = 1'b1;
      `PMT_OFF_STATUS: ok = 1'b1;
      `PMT_OFF_MASK: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : addr_hit

  // read data for an offset; unmapped offsets read zero
  function automatic logic [31:0] read_word(
    input logic [7:0] a,
    input period_match_timer8_pkg::timer_state_t s
  );
    logic [31:0] w;
    w = `PMT_RST_WORD;
    case (a)
      `PMT_OFF_CTRL: begin
        w[`PMT_CTRL_PRE_HI:`PMT_CTRL_PRE_LO] = s.pre_sel;
        w[`PMT_CTRL_RUN] = s.run;
        w[`PMT_CTRL_POST_HI:`PMT_CTRL_POST_LO] = s.post_sel;
      end
      `PMT_OFF_COUNT: w[7:0] = s.count;
      `PMT_OFF_PERIOD: w[7:0] = s.period;
      `PMT_OFF_STATUS: w[`PMT_EVT_MATCH] = s.flag;
      `PMT_OFF_MASK: w[`PMT_EVT_MATCH] = s.mask;
      default: w = `PMT_RST_WORD;
    endcase
    return w;
  endfunction : read_word

  // instruction clock enable, a quarter of the core rate
  instr_clock_divider #(
    .DIV(INSTR_DIV)
  ) u_instr_div (
    .clk(clk),
    .rst_n(rst_n_r),
    .tick(instr_tick)
  );

  // reset asserts at once and releases two edges later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  assign addr8 = 8'(paddr);

  // bus decode; a write lands only at the completing access edge
  always_comb begin
    xfer = psel && penable && st_r.pready &&
           (st_r.phase == period_match_timer8_pkg::PH_ACCESS);
    wr_ok = xfer && pwrite && pstrb[0] && addr_hit(addr8);
    wr_ctrl = wr_ok && (addr8 == `PMT_OFF_CTRL);
    wr_count = wr_ok && (addr8 == `PMT_OFF_COUNT);
    wr_period = wr_ok && (addr8 == `PMT_OFF_PERIOD);
    wr_status = wr_ok && (addr8 == `PMT_OFF_STATUS);
    wr_mask = wr_ok && (addr8 == `PMT_OFF_MASK);
  end

  // timer datapath terms, all but hit gated by run
  always_comb begin
    pre_tick = st_r.run && instr_tick &&
               (st_r.pre_cnt == pre_last(st_r.pre_sel));
    hit = (st_r.count == st_r.period);
    match = pre_tick && hit;
    post_done = match && (st_r.post_cnt == st_r.post_sel);
  end

  // next state of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.post_event = 1'b0;

    // bus phase sequencing, ready in the first access cycle, no wait state
    case (st_r.phase)
      period_match_timer8_pkg::PH_IDLE: begin
        if (psel && !penable) begin
          st_nxt.phase = period_match_timer8_pkg::PH_ACCESS;
          st_nxt.pready = 1'b1;
          st_nxt.prdata = read_word(addr8, st_r);
          st_nxt.pslverr = !addr_hit(addr8);
        end
      end
      period_match_timer8_pkg::PH_ACCESS: begin
        if (xfer) begin
          st_nxt.phase = period_match_timer8_pkg::PH_IDLE;
        end else begin
          st_nxt.pready = st_r.pready;
        end
      end
      default: begin
        st_nxt.phase = period_match_timer8_pkg::PH_IDLE;
      end
    endcase

    // prescaler runs on instruction ticks while enabled
    if (st_r.run && instr_tick) begin
      if (pre_tick) begin
        st_nxt.pre_cnt = `PMT_RST_SCALE_CNT;
      end else begin
        st_nxt.pre_cnt = st_r.pre_cnt + 4'h1;
      end
    end

    // count steps on prescaled ticks, match wraps it to zero
    if (pre_tick) begin
      if (hit) begin
        st_nxt.count = `PMT_RST_COUNT;
      end else begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end

    // postscaler counts matches only
    if (match) begin
      if (post_done) begin
        st_nxt.post_cnt = `PMT_RST_SCALE_CNT;
        st_nxt.post_event = 1'b1;
      end else begin
        st_nxt.post_cnt = st_r.post_cnt + 4'h1;
      end
    end

    // unscaled match as time base, one cycle wide
    st_nxt.match_out = match;

    // control write, bit 7 is simply not stored
    if (wr_ctrl) begin
      st_nxt.pre_sel = pwdata[`PMT_CTRL_PRE_HI:`PMT_CTRL_PRE_LO];
      st_nxt.run = pwdata[`PMT_CTRL_RUN];
      st_nxt.post_sel = pwdata[`PMT_CTRL_POST_HI:`PMT_CTRL_POST_LO];
      st_nxt.pre_cnt = `PMT_RST_SCALE_CNT;
      st_nxt.post_cnt = `PMT_RST_SCALE_CNT;
      st_nxt.count = st_nxt.count;
    end

    // software count write wins over a coincident tick
    if (wr_count) begin
      st_nxt.count = pwdata[7:0];
      st_nxt.pre_cnt = `PMT_RST_SCALE_CNT;
      st_nxt.post_cnt = `PMT_RST_SCALE_CNT;
    end

    // period is live at once, no shadow copy
    if (wr_period) begin
      st_nxt.period = pwdata[7:0];
    end

    if (wr_mask) begin
      st_nxt.mask = pwdata[`PMT_EVT_MATCH];
    end

    // write one to clear; a new event in the same cycle wins
    if (wr_status && pwdata[`PMT_EVT_MATCH]) begin
      st_nxt.flag = 1'b0;
    end
    if (post_done) begin
      st_nxt.flag = 1'b1;
    end

    // level interrupt, follows flag and mask in the same cycle
    st_nxt.irq = st_nxt.flag && st_nxt.mask;
  end

  // single state register, reset to documented values
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r.phase <= period_match_timer8_pkg::PH_IDLE;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata <= `PMT_RST_WORD;
      st_r.pre_sel <= `PMT_RST_PRE_SEL;
      st_r.run <= 1'b0;
      st_r.post_sel <= `PMT_RST_POST_SEL;
      st_r.count <= `PMT_RST_COUNT;
      st_r.period <= `PMT_RST_PERIOD;
      st_r.pre_cnt <= `PMT_RST_SCALE_CNT;
      st_r.post_cnt <= `PMT_RST_SCALE_CNT;
      st_r.flag <= 1'b0;
      st_r.mask <= 1'b0;
      st_r.match_out <= 1'b0;
      st_r.post_event <= 1'b0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output is a field of the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign time_base = st_r.match_out;
  assign post_event = st_r.post_event;
  assign irq = st_r.irq;

endmodule : period_match_timer8

// >>> verif/period_match_timer8_sva.sv
`timescale 1ns/100ps
module period_match_timer8_sva #(
  parameter int ADDR_W = 8
) (
  input logic clk,
  input logic rstn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic time_base,
  input logic post_event,
  input logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // bus handshake: one wait-free answer per setup
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  property p_err; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("refused read not zero");
  // matches come at most once per instruction tick
  property p_tb; time_base |=> !time_base [*3]; endproperty
  a_tb: assert property (p_tb) else $error("match pulses too close");
  property p_pe; post_event |=> !post_event [*3]; endproperty
  a_pe: assert property (p_pe) else $error("events too close");
  // an event always sits beside a match pulse
  property p_pm; post_event |-> (time_base || $past(time_base)) or ##1 time_base; endproperty
  a_pm: assert property (p_pm) else $error("event without match");
  // interrupt only moves after an event or a register access
  property p_ir;
    $rose(irq) |-> post_event || $past(post_event) || $past(pready) || $past(pready, 2);
  endproperty
  a_ir: assert property (p_ir) else $error("interrupt rose without cause");
  property p_if; $fell(irq) |-> $past(pready) || $past(pready, 2); endproperty
  a_if: assert property (p_if) else $error("interrupt fell without access");
  c_tb: cover property (time_base);
  c_pe: cover property (post_event);
  c_ir: cover property (irq);
  c_er: cover property (pready && pslverr);
endmodule : period_match_timer8_sva
bind period_match_timer8 period_match_timer8_sva #(.ADDR_W(ADDR_W)) sva_inst (.clk, .rstn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .time_base,
  .post_event, .irq);

// >>> verif/period_match_timer8_tb.sv
`timescale 1ns/100ps
module period_match_timer8_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, time_base, post_event, irq, re;
  int miscompares = 0, checks = 0, cyc = 0, t0, m;
  logic [31:0] c0;
  row_t rows[6] = '{'{8'h00, 32'h0000_00F3, 32'h0000_0073, 1'b0},
    '{8'h08, 32'h0000_005A, 32'h0000_005A, 1'b0}, '{8'h04, 32'h0000_003C, 32'h0000_003C, 1'b0},
    '{8'h10, 32'h0000_0001, 32'h0000_0001, 1'b0}, '{8'h14, 32'h0000_00AA, 32'h0000_0000, 1'b1},
    '{8'h05, 32'h0000_00AA, 32'h0000_0000, 1'b1}};
  period_match_timer8 period_match_timer8_inst (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .time_base(time_base),
    .post_event(post_event), .irq(irq));
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // one transfer, then an idle cycle so no signal is driven twice at one edge
  task xf(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask : xf
  task wt(input logic pe);
    do @(posedge clk); while ((pe ? post_event : time_base) !== 1'b1);
  endtask : wt
  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // watchdog well beyond the longest expected run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    xf(8'h00, 0, 0); chk("ctrl rst", 32'h0000_0000, rv);
    xf(8'h04, 0, 0); chk("count rst", 32'h0000_0000, rv);
    xf(8'h08, 0, 0); chk("period rst", 32'h0000_00FF, rv);
    foreach (rows[i]) begin
      xf(rows[i].a, 1, rows[i].d);
      chk("wr err", {31'h0, rows[i].e}, {31'h0, re});
      xf(rows[i].a, 0, 0);
      chk("rd data", rows[i].x, rv);
      chk("rd err", {31'h0, rows[i].e}, {31'h0, re});
    end
    // stopped timer keeps count across a control write
    xf(8'h04, 1, 32'h0000_0010); xf(8'h00, 1, 32'h0000_0070);
    repeat (20) @(posedge clk);
    xf(8'h04, 0, 0); chk("held count", 32'h0000_0010, rv);
    // free count: 40 cycles give ten instruction ticks
    xf(8'h08, 1, 32'h0000_00FF); xf(8'h00, 1, 32'h0000_0004);
    xf(8'h04, 0, 0); c0 = rv;
    repeat (37) @(posedge clk);
    xf(8'h04, 0, 0); chk("advance", c0 + 32'd10, rv);
    // match interval for every prescale code, period 2
    xf(8'h04, 1, 0); xf(8'h08, 1, 32'h0000_0002);
    for (int p = 0; p < 4; p++) begin
      xf(8'h00, 1, 32'h0000_0004 | p);
      wt(0); t0 = cyc; wt(0);
      chk("interval", 12 * (p == 0 ? 1 : p == 1 ? 4 : 16), cyc - t0);
    end
    // matches per event for postscale ends and middle, period 1
    xf(8'h08, 1, 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      m = k == 0 ? 0 : k == 1 ? 5 : 15;
      xf(8'h00, 1, 32'h0000_0004 | (m << 3));
      wt(1); t0 = 0;
      do begin @(posedge clk); t0 += time_base; end while (post_event !== 1'b1);
      chk("post ratio", m + 1, t0);
    end
    // flag latched, masked, cleared
    xf(8'h00, 1, 0); @(posedge clk);
    xf(8'h0C, 0, 0); chk("flag", 32'h0000_0001, rv);
    chk("irq on", 1, {31'h0, irq});
    xf(8'h10, 1, 0); @(posedge clk); chk("irq masked", 0, {31'h0, irq});
    xf(8'h0C, 1, 1); xf(8'h0C, 0, 0); chk("flag clr", 0, rv);
    xf(8'h10, 1, 1); @(posedge clk); chk("irq off", 0, {31'h0, irq});
    // a write with the low strobe clear must leave the period alone
    pstrb <= 4'h0;
    xf(8'h08, 1, 32'h0000_0033);
    pstrb <= 4'hF;
    xf(8'h08, 0, 0); chk("strobe off", 32'h0000_0001, rv);
    finish_test;
  end
endmodule : period_match_timer8_tb
